/* File: snb_serial_defines.vh */
// Purpose: Shared offsets, field positions and reset values of the serial ninth-bit block.
// Assumes: Included by bare name from the control design file of the block; the synchroniser does not include it.
// Notes: Definitions only.
`ifndef SNB_SERIAL_DEFINES_VH
`define SNB_SERIAL_DEFINES_VH

// Upper address byte of the blocking and non-blocking windows.
`define SNB_BASE_BLOCK_HI 8'h02
`define SNB_BASE_NONBLOCK_HI 8'h03

// Register offsets inside a window.
`define SNB_OFF_STATUS_ONE 8'h44
`define SNB_OFF_CONTROL_THREE 8'h46
`define SNB_OFF_DATA_BUFFER 8'h47
`define SNB_OFF_EVENT_STATUS 8'h48
`define SNB_OFF_EVENT_MASK 8'h49

// Third control register fields.
`define SNB_C3_RX_NINTH 7
`define SNB_C3_TX_NINTH 6
`define SNB_C3_TX_DIR 5
`define SNB_C3_TX_INV 4
`define SNB_C3_OVERRUN_IE 3
`define SNB_C3_NOISE_IE 2
`define SNB_C3_FRAMING_IE 1
`define SNB_C3_PARITY_IE 0

// First status register fields.
`define SNB_S1_TX_EMPTY 7
`define SNB_S1_RX_FULL 5
`define SNB_S1_OVERRUN 3
`define SNB_S1_NOISE 2
`define SNB_S1_FRAMING 1
`define SNB_S1_PARITY 0

// Event status and mask fields.
`define SNB_EV_RX_FULL 0
`define SNB_EV_TX_EMPTY 1
`define SNB_EV_OVERRUN 2
`define SNB_EV_RX_ERROR 3
`define SNB_EV_WIDTH 4

// Reset values.
`define SNB_RST_CONTROL_THREE 8'h00
`define SNB_RST_DATA_BUFFER 8'h00
`define SNB_RST_EVENT_MASK 4'h0

`endif

/* File: snb_sync2.v */
// Purpose: Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes: Each bit is an independent level; no bus coherence is promised.
// Notes: The first stage is read by the second stage only.
`timescale 1ns/1ps

module snb_sync2
#(
    parameter WIDTH = 1
)
(
    clock,
    nrst,
    asyncIn,
    syncOut
);
    input wire clock;
    input wire nrst;
    input wire [WIDTH-1:0] asyncIn;
    output wire [WIDTH-1:0] syncOut;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : gStage
            reg meta_r;
            reg stable_r;
            always @(posedge clock or negedge nrst)
            begin
                if (!nrst)
                begin
                    meta_r <= 1'b0;
                    stable_r <= 1'b0;
                end
                else
                begin
                    meta_r <= asyncIn[i];
                    stable_r <= meta_r;
                end
            end
            assign syncOut[i] = stable_r;
        end
    endgenerate
endmodule // snb_sync2

/* File: snb_serial_ctrl.v */
// Purpose: Third control register, data register and error interrupts of an asynchronous serial interface.
// Assumes: Receiver and transmit shifter run on the same clock; only the pin input is asynchronous.
// Notes: Registers answer in both the blocking and the non-blocking address window.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "snb_serial_defines.vh"

module snb_serial_ctrl
(
    clock,
    nrst,
    regAddr,
    regWrData,
    regWr,
    regRd,
    regRdData,
    nineBitMode,
    loopSelect,
    receiveSourceSelect,
    rxDone,
    rxChar,
    rxNoise,
    rxFraming,
    rxParity,
    txTake,
    txChar,
    txFull,
    txLineBit,
    txPinIn,
    txPinOut,
    txPinOeN,
    singleWireRx,
    irq
);
    input wire clock;
    input wire nrst;
    input wire [15:0] regAddr;
    input wire [7:0] regWrData;
    input wire regWr;
    input wire regRd;
    output reg [7:0] regRdData;
    input wire nineBitMode;
    input wire loopSelect;
    input wire receiveSourceSelect;
    input wire rxDone;
    input wire [8:0] rxChar;
    input wire rxNoise;
    input wire rxFraming;
    input wire rxParity;
    input wire txTake;
    output reg [8:0] txChar;
    output reg txFull;
    input wire txLineBit;
    input wire txPinIn;
    output reg txPinOut;
    output reg txPinOeN;
    output wire singleWireRx;
    output reg irq;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.

    reg [7:0] control3_r;
    reg [7:0] rxData_r;
    reg rxNinth_r;
    reg rxFull_r;
    reg overrun_r;
    reg noise_r;
    reg framing_r;
    reg parity_r;
    reg [4:0] armed_r;
    reg [`SNB_EV_WIDTH-1:0] evStat_r;
    reg [`SNB_EV_WIDTH-1:0] evMask_r;

    wire windowHit;
    wire [7:0] offset;
    wire selStatus;
    wire selControl;
    wire selData;
    wire selEvStat;
    wire selEvMask;

    assign windowHit = (regAddr[15:8] == `SNB_BASE_BLOCK_HI) ||
                       (regAddr[15:8] == `SNB_BASE_NONBLOCK_HI);
    assign offset = regAddr[7:0];
    assign selStatus = windowHit && (offset == `SNB_OFF_STATUS_ONE);
    assign selControl = windowHit && (offset == `SNB_OFF_CONTROL_THREE);
    assign selData = windowHit && (offset == `SNB_OFF_DATA_BUFFER);
    assign selEvStat = windowHit && (offset == `SNB_OFF_EVENT_STATUS);
    assign selEvMask = windowHit && (offset == `SNB_OFF_EVENT_MASK);

    wire statusRead;
    wire dataRead;
    wire dataWrite;

    assign statusRead = regRd && selStatus;
    assign dataRead = regRd && selData;
    assign dataWrite = regWr && selData;

    ////////////////////////////////////////////////////////////////////////////
    // Third control register; bit 7 is never stored from the bus.

    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            control3_r <= `SNB_RST_CONTROL_THREE;
        end
        else if (regWr && selControl)
        begin
            control3_r <= {1'b0, regWrData[6:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive buffer and status flags.

    // A data read clears only the flags that a status read armed before it.
    wire [4:0] flagVec;
    wire [4:0] clearVec;
    wire acceptRx;
    wire rxOverrun;

    assign flagVec = {rxFull_r, overrun_r, noise_r, framing_r, parity_r};
    assign clearVec = dataRead ? armed_r : 5'h00;
    assign acceptRx = rxDone && (!rxFull_r || clearVec[4]);
    assign rxOverrun = rxDone && !acceptRx;

    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rxData_r <= `SNB_RST_DATA_BUFFER;
            rxNinth_r <= 1'b0;
            rxFull_r <= 1'b0;
            overrun_r <= 1'b0;
            noise_r <= 1'b0;
            framing_r <= 1'b0;
            parity_r <= 1'b0;
            armed_r <= 5'h00;
        end
        else
        begin
            if (acceptRx)
            begin
                rxData_r <= rxChar[7:0];
                rxNinth_r <= nineBitMode & rxChar[8];
            end
            // A new event wins over a clear in the same cycle.
            rxFull_r <= acceptRx | (rxFull_r & ~clearVec[4]);
            overrun_r <= rxOverrun | (overrun_r & ~clearVec[3]);
            noise_r <= (acceptRx & rxNoise) | (noise_r & ~clearVec[2]);
            framing_r <= (acceptRx & rxFraming) | (framing_r & ~clearVec[1]);
            parity_r <= (acceptRx & rxParity) | (parity_r & ~clearVec[0]);
            if (statusRead)
            begin
                armed_r <= flagVec;
            end
            else if (dataRead)
            begin
                armed_r <= 5'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit buffer.

    // The held ninth bit rides along with every byte written in nine-bit mode.
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            txChar <= 9'h000;
            txFull <= 1'b0;
        end
        else
        begin
            if (dataWrite)
            begin
                txChar <= {nineBitMode & control3_r[`SNB_C3_TX_NINTH], regWrData};
            end
            txFull <= dataWrite | (txFull & ~txTake);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit pin.

    wire singleWire;

    assign singleWire = loopSelect && receiveSourceSelect;

    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            txPinOut <= 1'b1;
            txPinOeN <= 1'b0;
        end
        else
        begin
            txPinOut <= txLineBit ^ control3_r[`SNB_C3_TX_INV];
            txPinOeN <= singleWire & control3_r[`SNB_C3_TX_DIR];
        end
    end

    snb_sync2
    #(
        .WIDTH(1)
    )
    uPinSync
    (
        .clock(clock),
        .nrst(nrst),
        .asyncIn(txPinIn),
        .syncOut(singleWireRx)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Event status, mask and interrupt.

    wire [`SNB_EV_WIDTH-1:0] evSet;
    wire [`SNB_EV_WIDTH-1:0] evClr;
    wire [3:0] errReq;

    assign evSet = {acceptRx & (rxNoise | rxFraming | rxParity), rxOverrun, txTake, acceptRx};
    assign evClr = (regWr && selEvStat) ? regWrData[`SNB_EV_WIDTH-1:0] : {`SNB_EV_WIDTH{1'b0}};
    assign errReq[3] = overrun_r & control3_r[`SNB_C3_OVERRUN_IE];
    assign errReq[2] = noise_r & control3_r[`SNB_C3_NOISE_IE];
    assign errReq[1] = framing_r & control3_r[`SNB_C3_FRAMING_IE];
    assign errReq[0] = parity_r & control3_r[`SNB_C3_PARITY_IE];

    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            evStat_r <= {`SNB_EV_WIDTH{1'b0}};
            evMask_r <= `SNB_RST_EVENT_MASK;
            irq <= 1'b0;
        end
        else
        begin
            evStat_r <= evSet | (evStat_r & ~evClr);
            if (regWr && selEvMask)
            begin
                evMask_r <= regWrData[`SNB_EV_WIDTH-1:0];
            end
            irq <= (|errReq) | (|(evStat_r & evMask_r));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe.

    reg [7:0] rdMux;

    always @*
    begin
        rdMux = 8'h00;
        if (selStatus)
        begin
            rdMux[`SNB_S1_TX_EMPTY] = ~txFull;
            rdMux[`SNB_S1_RX_FULL] = rxFull_r;
            rdMux[`SNB_S1_OVERRUN] = overrun_r;
            rdMux[`SNB_S1_NOISE] = noise_r;
            rdMux[`SNB_S1_FRAMING] = framing_r;
            rdMux[`SNB_S1_PARITY] = parity_r;
        end
        else if (selControl)
        begin
            rdMux = {rxNinth_r, control3_r[6:0]};
        end
        else if (selData)
        begin
            rdMux = rxData_r;
        end
        else if (selEvStat)
        begin
            rdMux[`SNB_EV_WIDTH-1:0] = evStat_r;
        end
        else if (selEvMask)
        begin
            rdMux[`SNB_EV_WIDTH-1:0] = evMask_r;
        end
    end

    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            regRdData <= 8'h00;
        end
        else
        begin
            regRdData <= regRd ? rdMux : 8'h00;
        end
    end
endmodule // snb_serial_ctrl

/* File: snb_serial_ctrl_props.sv */
// Purpose: Port-level checks for the serial ninth-bit block.
// Assumes: One clock domain; nrst is asynchronous and active low.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps
module snb_serial_ctrl_props
(
    input wire clock,
    input wire nrst,
    input wire [15:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWr,
    input wire regRd,
    input wire [7:0] regRdData,
    input wire nineBitMode,
    input wire loopSelect,
    input wire receiveSourceSelect,
    input wire rxDone,
    input wire txTake,
    input wire [8:0] txChar,
    input wire txFull,
    input wire txLineBit,
    input wire txPinIn,
    input wire txPinOut,
    input wire txPinOeN,
    input wire singleWireRx,
    input wire irq
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!nrst);
    wire dataWr = regWr && regAddr[15:9] == 7'h01 && regAddr[7:0] == 8'h47;
    ////////////////////////////////////////////////////////////////////////////
    a_oe_single_wire: assert property (txPinOeN |-> $past(loopSelect && receiveSourceSelect))
        else $error("pin released outside single-wire mode");
    a_read_idle: assert property (!$past(regRd) |-> regRdData == 8'h00)
        else $error("read data outside its cycle");
    a_read_unmapped: assert property (regRd && regAddr[15:9] != 7'h01 |=> regRdData == 8'h00)
        else $error("unmapped read returned data");
    a_tx_load: assert property (dataWr |=> txFull && txChar[7:0] == $past(regWrData))
        else $error("data write not loaded");
    a_tx_ninth_off: assert property (dataWr && !nineBitMode |=> !txChar[8])
        else $error("ninth bit sent in eight-bit mode");
    a_tx_take: assert property (txTake && !dataWr |=> !txFull)
        else $error("buffer still full after take");
    a_irq_cause: assert property ($rose(irq) |-> $past(rxDone, 2) || $past(regWr, 2) || $past(txTake, 2))
        else $error("interrupt without cause");
    a_sync_delay: assert property ($past(nrst, 2) |-> singleWireRx == $past(txPinIn, 2))
        else $error("pin input latency wrong");
    a_pin_follow: assert property ($past(nrst) && $changed(txPinOut)
        |-> $past(txLineBit) != $past(txLineBit, 2) || $past(regWr, 2))
        else $error("pin changed without cause");
endmodule // snb_serial_ctrl_props

bind snb_serial_ctrl snb_serial_ctrl_props u_props (.clock, .nrst, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .nineBitMode, .loopSelect, .receiveSourceSelect, .rxDone, .txTake, .txChar, .txFull,
    .txLineBit, .txPinIn, .txPinOut, .txPinOeN, .singleWireRx, .irq);

/* File: snb_far_end.sv */
// Purpose: Receiver and transmit shifter standing behind the serial block.
// Assumes: Same clock as the block.
// Notes: Released character lines show the inverse of the last value.
`timescale 1ns/1ps
module snb_far_end
(
    input wire clock,
    input wire [8:0] txChar,
    output reg rxDone,
    output reg [8:0] rxChar,
    output reg rxNoise,
    output reg rxFraming,
    output reg rxParity,
    output reg txTake,
    output reg txLineBit
);
    initial
    begin
        {rxDone, rxNoise, rxFraming, rxParity, txTake} = 5'h00;
        rxChar = 9'h000;
        txLineBit = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    task send(input [8:0] ch, input [2:0] err);
        begin
            @(posedge clock);
            rxDone <= 1'b1;
            rxChar <= ch;
            {rxNoise, rxFraming, rxParity} <= err;
            @(posedge clock);
            rxDone <= 1'b0;
            rxChar <= ~ch;
            {rxNoise, rxFraming, rxParity} <= ~err;
        end
    endtask
    // Takes the buffer after a chosen lag, then shifts start and data bits.
    task take(input integer lag);
        integer k;
        begin
            repeat (lag) @(posedge clock);
            txTake <= 1'b1;
            @(posedge clock);
            txTake <= 1'b0;
            txLineBit <= 1'b0;
            for (k = 0; k < 9; k = k + 1)
            begin
                @(posedge clock);
                txLineBit <= txChar[k];
            end
            @(posedge clock);
            txLineBit <= 1'b1;
        end
    endtask
endmodule // snb_far_end

/* File: test_snb_serial_ctrl.sv */
// Purpose: Register-level test of the serial ninth-bit block.
// Assumes: 100 ns clock; reset held for 20 cycles.
// Notes: The far end model supplies characters and takes the buffer.
`timescale 1ns/1ps
module test_snb_serial_ctrl;
    reg clock = 1'b0;
    reg nrst = 1'b0;
    reg [15:0] regAddr = 16'h0000;
    reg [7:0] regWrData = 8'h00;
    reg regWr = 1'b0, regRd = 1'b0, nineBitMode = 1'b0, txPinIn = 1'b0;
    reg loopSelect = 1'b0, receiveSourceSelect = 1'b0;
    wire [7:0] regRdData;
    wire [8:0] rxChar, txChar;
    wire rxDone, rxNoise, rxFraming, rxParity, txTake, txFull, txLineBit, txPinOut, txPinOeN, singleWireRx, irq;
    integer fails = 0, n_tests = 0, i;
    always #50 clock = ~clock;
    snb_serial_ctrl DUT (.clock, .nrst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .nineBitMode,
        .loopSelect, .receiveSourceSelect, .rxDone, .rxChar, .rxNoise, .rxFraming, .rxParity, .txTake,
        .txChar, .txFull, .txLineBit, .txPinIn, .txPinOut, .txPinOeN, .singleWireRx, .irq);
    snb_far_end u_far (.clock, .txChar, .rxDone, .rxChar, .rxNoise, .rxFraming, .rxParity, .txTake, .txLineBit);
    ////////////////////////////////////////////////////////////////////////////
    task check(input [8:0] seen, input [8:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp)
            begin
                fails = fails + 1;
                $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [15:0] a, input [7:0] d);
        begin
            @(posedge clock);
            regWr <= 1'b1;
            regAddr <= a;
            regWrData <= d;
            @(posedge clock);
            regWr <= 1'b0;
        end
    endtask
    task rd(input [15:0] a, input [7:0] e);
        begin
            @(posedge clock);
            regRd <= 1'b1;
            regAddr <= a;
            @(posedge clock);
            regRd <= 1'b0;
            #1 check({1'b0, regRdData}, {1'b0, e});
        end
    endtask
    task print_verdict;
        begin
            $display("fails=%0d n_tests=%0d", fails, n_tests);
            if (fails == 0 && n_tests > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial
    begin
        #200000;
        fails = fails + 1;
        print_verdict;
    end
    initial
    begin
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        rd(16'h0246, 8'h00);
        rd(16'h0247, 8'h00);
        wr(16'h0246, 8'hFF);
        wr(16'h0146, 8'h00);
        rd(16'h0246, 8'h7F);
        rd(16'h0346, 8'h7F);
        rd(16'h0146, 8'h00);
        check({8'h00, txPinOut}, 9'h000);
        check({8'h00, txPinOeN}, 9'h000);
        @(posedge clock);
        loopSelect <= 1'b1;
        receiveSourceSelect <= 1'b1;
        txPinIn <= 1'b1;
        repeat (3) @(posedge clock);
        #1 check({7'h00, txPinOeN, singleWireRx}, 9'h003);
        @(posedge clock);
        loopSelect <= 1'b0;
        nineBitMode <= 1'b1;
        wr(16'h0246, 8'h40);
        wr(16'h0347, 8'hA5);
        #1 check(txChar, 9'h1A5);
        wr(16'h0247, 8'h5A);
        #1 check(txChar, 9'h15A);
        u_far.take(3);
        #1 check({8'h00, txFull}, 9'h000);
        u_far.send(9'h1C3, 3'b000);
        rd(16'h0246, 8'hC0);
        rd(16'h0247, 8'hC3);
        rd(16'h0244, 8'hA0);
        rd(16'h0247, 8'hC3);
        rd(16'h0244, 8'h80);
        for (i = 0; i < 8; i = i + 1)
        begin
            wr(16'h0246, i[0] ? 8'h01 << i[2:1] : 8'h00);
            u_far.send(9'h055, i < 6 ? 3'b001 << i[2:1] : 3'b000);
            if (i > 5)
                u_far.send(9'h0AA, 3'b000);
            repeat (2) @(posedge clock);
            #1 check({8'h00, irq}, {8'h00, i[0]});
            rd(16'h0244, 8'hA0 | 8'h01 << i[2:1]);
            rd(16'h0247, 8'h55);
            repeat (2) @(posedge clock);
            #1 check({8'h00, irq}, 9'h000);
        end
        @(posedge clock);
        nineBitMode <= 1'b0;
        wr(16'h0246, 8'h40);
        wr(16'h0247, 8'h3C);
        #1 check(txChar, 9'h03C);
        u_far.send(9'h1C3, 3'b000);
        rd(16'h0246, 8'h40);
        rd(16'h0247, 8'hC3);
        wr(16'h0249, 8'h01);
        repeat (2) @(posedge clock);
        #1 check({8'h00, irq}, 9'h001);
        wr(16'h0248, 8'h0F);
        repeat (2) @(posedge clock);
        #1 check({8'h00, irq}, 9'h000);
        print_verdict;
    end
endmodule // test_snb_serial_ctrl
